// ==== shared/tmirq_pkg.sv ====
package tmirq_pkg;
	localparam logic [11:0] TMIRQ_T1_OFF = 12'h000;
	localparam logic [11:0] TMIRQ_T2_OFF = 12'h004;
	localparam logic [11:0] TMIRQ_CTL_OFF = 12'h008;
	localparam logic [11:0] TMIRQ_STAT_OFF = 12'h00c;
	localparam logic [11:0] TMIRQ_MASK_OFF = 12'h010;
	localparam int TMIRQ_AF_BIT = 5;
	localparam int TMIRQ_PF_BIT = 4;
	localparam int TMIRQ_AE_BIT = 1;
	localparam int TMIRQ_PE_BIT = 0;
	localparam logic [7:0] TMIRQ_IMPL_MASK = 8'h33;
	localparam logic [7:0] TMIRQ_REG_RST = 8'h00;
	localparam logic [3:0] TMIRQ_EV_RST = 4'h0;
	localparam logic TMIRQ_GIE_RST = 1'b0;

	typedef struct packed {
		logic a_match;
		logic p_match;
	} tmirq_ev_t;

	typedef struct packed {
		logic a_flag;
		logic p_flag;
		logic a_en;
		logic p_en;
	} tmirq_chan_t;
endpackage

// ==== hw/tmirq_chan.sv ====
`timescale 1ns/10ps
`default_nettype none
module tmirq_chan
	import tmirq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire tmirq_ev_t ev,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output tmirq_chan_t st,
	output logic [7:0] rdata
);
	tmirq_chan_t st_r;

	// hardware set beats a same-cycle software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= TMIRQ_EV_RST;
		end else begin
			st_r.a_flag <= ev.a_match |
				(wr ? wdata[TMIRQ_AF_BIT] : st_r.a_flag);
			st_r.p_flag <= ev.p_match |
				(wr ? wdata[TMIRQ_PF_BIT] : st_r.p_flag);
			if (wr) begin
				st_r.a_en <= wdata[TMIRQ_AE_BIT];
				st_r.p_en <= wdata[TMIRQ_PE_BIT];
			end
		end
	end

	assign st = st_r;
	always_comb begin
		rdata = 8'h00;
		rdata[TMIRQ_AF_BIT] = st_r.a_flag;
		rdata[TMIRQ_PF_BIT] = st_r.p_flag;
		rdata[TMIRQ_AE_BIT] = st_r.a_en;
		rdata[TMIRQ_PE_BIT] = st_r.p_en;
	end

	a_flag_sticky: assert property (
		@(posedge clk) disable iff (!rst_n)
		st_r.a_flag && !wr |=> st_r.a_flag)
		else $error("a flag dropped without write");
	a_event_sets: assert property (
		@(posedge clk) disable iff (!rst_n)
		ev.p_match |=> st_r.p_flag)
		else $error("p event did not set flag");
	a_a_event_sets: assert property (
		@(posedge clk) disable iff (!rst_n)
		ev.a_match |=> st_r.a_flag)
		else $error("a event did not set flag");
endmodule
`default_nettype wire

// ==== hw/tmirq_top.sv ====
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tmirq_top
	import tmirq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic t1_match_a,
	input wire logic t1_match_p,
	input wire logic t2_match_a,
	input wire logic t2_match_p,
	input wire logic irq_taken,
	output logic irq_req,
	output logic global_irq_enable,
	output logic irq
);
	tmirq_chan_t ch1, ch2;
	tmirq_ev_t ev1, ev2;
	logic [7:0] rd1, rd2;
	logic [3:0] stat_r, mask_r, ev_vec;
	logic gie_r, irq_req_r, irq_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;
	logic acc, wr1, wr2;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	// one-cycle wait state: access completes on the second penable edge
	assign acc = psel && penable && !pready_r;
	assign wr1 = acc && pwrite && hit(paddr, TMIRQ_T1_OFF);
	assign wr2 = acc && pwrite && hit(paddr, TMIRQ_T2_OFF);
	assign ev1 = '{a_match: t1_match_a, p_match: t1_match_p};
	assign ev2 = '{a_match: t2_match_a, p_match: t2_match_p};
	assign ev_vec = {t2_match_a, t2_match_p, t1_match_a, t1_match_p};

	tmirq_chan u_t1 (.clk(clk), .rst_n(rst_n), .ev(ev1), .wr(wr1),
		.wdata(pwdata[7:0]), .st(ch1), .rdata(rd1));
	tmirq_chan u_t2 (.clk(clk), .rst_n(rst_n), .ev(ev2), .wr(wr2),
		.wdata(pwdata[7:0]), .st(ch2), .rdata(rd2));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= acc;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			if (acc) begin
				case (paddr)
					TMIRQ_T1_OFF: prdata_r <= {24'h000000, rd1};
					TMIRQ_T2_OFF: prdata_r <= {24'h000000, rd2};
					TMIRQ_CTL_OFF: prdata_r <= {31'h0, gie_r};
					TMIRQ_STAT_OFF: prdata_r <= {28'h0, stat_r};
					TMIRQ_MASK_OFF: prdata_r <= {28'h0, mask_r};
					default: pslverr_r <= 1'b1;
				endcase
			end
		end
	end

	// global enable: software sets, a taken interrupt clears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gie_r <= TMIRQ_GIE_RST;
		end else if (irq_taken) begin
			gie_r <= 1'b0;
		end else if (acc && pwrite && hit(paddr, TMIRQ_CTL_OFF)) begin
			gie_r <= pwdata[0];
		end
	end

	// event status for the bus interrupt, write one to clear, set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= TMIRQ_EV_RST;
			mask_r <= TMIRQ_EV_RST;
		end else begin
			if (acc && pwrite && hit(paddr, TMIRQ_STAT_OFF)) begin
				stat_r <= (stat_r & ~pwdata[3:0]) | ev_vec;
			end else begin
				stat_r <= stat_r | ev_vec;
			end
			if (acc && pwrite && hit(paddr, TMIRQ_MASK_OFF)) begin
				mask_r <= pwdata[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			irq_req_r <= gie_r && !irq_taken &&
				((ch1.a_flag && ch1.a_en) || (ch1.p_flag && ch1.p_en) ||
				(ch2.a_flag && ch2.a_en) || (ch2.p_flag && ch2.p_en));
			irq_r <= |(stat_r & mask_r);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq_req = irq_req_r;
	assign global_irq_enable = gie_r;
	assign irq = irq_r;

	a_gie_cleared: assert property (
		@(posedge clk) disable iff (!rst_n)
		irq_taken |=> !gie_r)
		else $error("global enable not cleared on take");
	a_req_needs_gie: assert property (
		@(posedge clk) disable iff (!rst_n)
		irq_req_r |-> $past(gie_r))
		else $error("request without global enable");
	a_req_needs_en: assert property (
		@(posedge clk) disable iff (!rst_n)
		gie_r && !irq_taken && !ch1.a_en && !ch1.p_en && !ch2.a_en
		&& !ch2.p_en |=> !irq_req_r)
		else $error("request with all enables off");
	a_flag_no_en: assert property (
		@(posedge clk) disable iff (!rst_n)
		t1_match_a |=> ch1.a_flag)
		else $error("flag not set while disabled");
	a_rsvd_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd1[7:6] == 2'b00 && rd1[3:2] == 2'b00 &&
		rd2[7:6] == 2'b00 && rd2[3:2] == 2'b00)
		else $error("reserved bits not zero");
	a_p_flag_set: assert property (
		@(posedge clk) disable iff (!rst_n)
		t2_match_p |=> ##1 (rd2[TMIRQ_PF_BIT] || $past(wr2)))
		else $error("p flag not visible");
	a_set_wins: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr1 && !pwdata[TMIRQ_PF_BIT] && t1_match_p |=> ch1.p_flag)
		else $error("set lost to clear");
	a_en_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr2 |=> ch2.a_en == $past(pwdata[TMIRQ_AE_BIT]))
		else $error("enable write lost");
	a_ready_one: assert property (
		@(posedge clk) disable iff (!rst_n)
		pready_r |=> !pready_r)
		else $error("pready held");
	a_ready_follows: assert property (
		@(posedge clk) disable iff (!rst_n)
		acc |=> pready_r)
		else $error("access not answered");
	// the master still holds the address while pready stands
	a_rd_unimpl: assert property (
		@(posedge clk) disable iff (!rst_n)
		pready_r && psel && !pwrite &&
		(paddr == TMIRQ_T1_OFF || paddr == TMIRQ_T2_OFF) |->
		prdata_r[31:6] == 26'h0 && prdata_r[3:2] == 2'b00)
		else $error("unimplemented bits read nonzero");
	a_req_a_en: assert property (
		@(posedge clk) disable iff (!rst_n)
		gie_r && !irq_taken && ch1.a_flag && ch1.a_en |=> irq_req_r)
		else $error("enabled a flag gave no request");
	a_req_p_en: assert property (
		@(posedge clk) disable iff (!rst_n)
		gie_r && !irq_taken && ch2.p_flag && ch2.p_en |=> irq_req_r)
		else $error("enabled p flag gave no request");
	a_gie_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		acc && pwrite && hit(paddr, TMIRQ_CTL_OFF) && !irq_taken |=>
		gie_r == $past(pwdata[0]))
		else $error("global enable write lost");
	a_stat_set: assert property (
		@(posedge clk) disable iff (!rst_n)
		t1_match_p |=> stat_r[0])
		else $error("status not set by event");
	a_stat_clear: assert property (
		@(posedge clk) disable iff (!rst_n)
		acc && pwrite && hit(paddr, TMIRQ_STAT_OFF) && pwdata[0] &&
		!t1_match_p |=> !stat_r[0])
		else $error("status not cleared by write");
	a_irq_on: assert property (
		@(posedge clk) disable iff (!rst_n)
		(stat_r & mask_r) != 4'h0 |=> irq_r)
		else $error("unmasked status gave no irq");
	a_irq_off: assert property (
		@(posedge clk) disable iff (!rst_n)
		(stat_r & mask_r) == 4'h0 |=> !irq_r)
		else $error("irq without unmasked status");
	a_err_ready: assert property (
		@(posedge clk) disable iff (!rst_n)
		pslverr_r |-> pready_r)
		else $error("error outside ready");
	c_taken: cover property (@(posedge clk) disable iff (!rst_n)
		irq_req_r ##1 irq_taken);
	c_collide: cover property (@(posedge clk) disable iff (!rst_n)
		wr1 && t1_match_a);
	c_set_wins: cover property (@(posedge clk) disable iff (!rst_n)
		wr1 && t1_match_p);
	c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq_r);
endmodule
`default_nettype wire

// ==== verif/tmirq_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// stands in for the timers and the processor's interrupt entry
module tmirq_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] fire,
	input wire logic take_en,
	input wire logic irq_req,
	output logic [3:0] ev,
	output logic irq_taken
);
	// one event per cycle that fire is high, order t1a,t1p,t2a,t2p
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ev <= 4'h0;
		else ev <= fire;
	end
	// single pulse; the gap lets the global enable fall before a retake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) irq_taken <= 1'b0;
		else irq_taken <= take_en & irq_req & ~irq_taken;
	end
endmodule
`default_nettype wire

// ==== verif/tmirq_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tmirq_top_test;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, irq_req, gie, irq, taken, take_en = 0;
	logic [3:0] fire = 4'h0, ev;
	int num_errors = 0, compares = 0, cyc = 0;
	always #2.5 clk = ~clk;
	tmirq_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .t1_match_a(ev[3]),
		.t1_match_p(ev[2]), .t2_match_a(ev[1]), .t2_match_p(ev[0]),
		.irq_taken(taken), .irq_req(irq_req), .global_irq_enable(gie),
		.irq(irq));
	tmirq_partner u_far (.clk(clk), .rst_n(rst_n), .fire(fire),
		.take_en(take_en), .irq_req(irq_req), .ev(ev), .irq_taken(taken));
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic pulse(input logic [3:0] v);
		fire <= v;
		@(posedge clk);
		fire <= 4'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// hang guard; a full pass takes about 130 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc(12'h000, 32'h0);
		apb(1'b1, 12'h000, 32'hff);
		rc(12'h000, 32'h33);
		`CHK(er, 1'b0)
		apb(1'b1, 12'h004, 32'hcc);
		rc(12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'h0);
		pulse(4'b1000);
		rc(12'h000, 32'h20);
		pulse(4'b0001);
		rc(12'h004, 32'h10);
		apb(1'b1, 12'h014, 32'h1);
		`CHK(er, 1'b1)
		rc(12'h014, 32'h0);
		`CHK(er, 1'b1)
		apb(1'b1, 12'h008, 32'h1);
		`CHK(irq_req, 1'b0)
		rc(12'h008, 32'h1);
		apb(1'b1, 12'h000, 32'h22);
		`CHK(irq_req, 1'b1)
		take_en <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(gie, 1'b0)
		`CHK(irq_req, 1'b0)
		rc(12'h008, 32'h0);
		take_en <= 1'b0;
		apb(1'b1, 12'h000, 32'h01);
		pulse(4'b0100);
		rc(12'h000, 32'h11);
		apb(1'b1, 12'h008, 32'h1);
		`CHK(irq_req, 1'b1)
		rc(12'h00c, 32'h7);
		apb(1'b1, 12'h00c, 32'hf);
		pulse(4'b0100);
		apb(1'b1, 12'h010, 32'h1);
		`CHK(irq, 1'b1)
		rc(12'h010, 32'h1);
		apb(1'b1, 12'h010, 32'h0);
		`CHK(irq, 1'b0)
		apb(1'b1, 12'h010, 32'h1);
		apb(1'b1, 12'h00c, 32'h1);
		`CHK(irq, 1'b0)
		// events land at the very edge that takes the clearing write
		fire <= 4'b1100;
		fork
			apb(1'b1, 12'h000, 32'h0);
			begin
				@(posedge clk);
				fire <= 4'h0;
			end
		join
		rc(12'h000, 32'h30);
		close_out;
	end
endmodule
`default_nettype wire
